// file: shared/tas_map.vh
// register map, field codes and timing constants of the trigger arming sequencer
`ifndef TAS_MAP_VH
`define TAS_MAP_VH
// register byte offsets
`define TAS_OFF_CMD      12'h000
`define TAS_OFF_CFG      12'h004
`define TAS_OFF_STATUS   12'h008
`define TAS_OFF_IRQ_STAT 12'h00C
`define TAS_OFF_IRQ_EN   12'h010
`define TAS_OFF_IRQ_CLR  12'h014
`define TAS_OFF_ERR      12'h018
// command register fields
`define TAS_CMD_OP_LSB   0
`define TAS_CMD_OP_MSB   3
`define TAS_CMD_CH_LSB   4
`define TAS_CMD_CH_MSB   5
`define TAS_CMD_ARG_BIT  8
// command opcodes
`define TAS_OP_NONE      4'h0
`define TAS_OP_ABORT     4'h1
`define TAS_OP_SINGLE    4'h2
`define TAS_OP_CONT      4'h3
`define TAS_OP_CONT_ALL  4'h4
`define TAS_OP_SINGLE_ALL 4'h5
`define TAS_OP_TRIG_NOW  4'h6
`define TAS_OP_LOCAL     4'h7
// channel suffix codes
`define TAS_SUFFIX_A     2'h1
`define TAS_SUFFIX_B     2'h2
// trigger source codes, 3 bits per channel in the config register
`define TAS_SRC_BUS      3'h0
`define TAS_SRC_EXT      3'h1
`define TAS_SRC_HOLD     3'h2
`define TAS_SRC_IMM      3'h3
`define TAS_SRC_INT      3'h4
`define TAS_CFG_SRC_A_LSB 0
`define TAS_CFG_SRC_B_LSB 4
// sequencing states
`define TAS_ST_IDLE      2'h0
`define TAS_ST_WAIT      2'h1
`define TAS_ST_MEAS      2'h2
// error codes (magnitude of the negative instrument code)
`define TAS_ERR_NONE     8'h00
`define TAS_ERR_TRIG_IGN 8'hD3
`define TAS_ERR_INIT_IGN 8'hD5
`define TAS_ERR_SUFFIX   8'h72
// interrupt status bits
`define TAS_IRQ_DONE_A   0
`define TAS_IRQ_DONE_B   1
`define TAS_IRQ_ERR      2
`define TAS_IRQ_W        3
// measurement time
`define TAS_MEAS_NS      1000
`define TAS_CLK_NS       50
`define TAS_MEAS_CYC     (`TAS_MEAS_NS / `TAS_CLK_NS)
`endif

// file: design/tas_sequencer.v
// two-channel trigger arming sequencer with apb register access
//
// Decided for this implementation: the register addresses and the APB slave port.
`include "tas_map.vh"
module tas_sequencer #(
    parameter NUM_CH   = 2,
    parameter RES_W    = 16,
    parameter MEAS_CYC = `TAS_MEAS_CYC
) (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        srst_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // trigger events and measurement data
    input  wire [1:0]  ext_trig_i,
    input  wire [1:0]  int_trig_i,
    input  wire [RES_W-1:0] meas_data_a_i,
    input  wire [RES_W-1:0] meas_data_b_i,
    // status
    output reg  [1:0]  pending_o,
    output reg  [1:0]  measuring_o,
    output reg         irq_o
);
    localparam ST_IDLE = `TAS_ST_IDLE;
    localparam ST_WAIT = `TAS_ST_WAIT;
    localparam ST_MEAS = `TAS_ST_MEAS;

    ////////////////////////////////////////////////////////////////////////
    reg  [1:0]       state_reg [0:1];
    reg  [1:0]       state_next [0:1];
    reg  [1:0]       cont_reg;
    reg  [1:0]       cont_next;
    reg              cont_all_reg;
    reg              cont_all_next;
    reg  [7:0]       cfg_reg;
    reg  [15:0]      cnt_reg [0:1];
    reg  [RES_W-1:0] result_reg [0:1];
    reg  [1:0]       fresh_reg;
    reg  [7:0]       err_reg;
    reg  [7:0]       err_next;
    reg  [`TAS_IRQ_W-1:0] irq_stat_reg;
    reg  [`TAS_IRQ_W-1:0] irq_en_reg;
    reg  [1:0]       done_set;
    reg  [2:0]       src [0:1];
    reg  [1:0]       trig_hit;
    reg              err_set;
    integer          c;
    integer          k;
    integer          j;
    integer          t;
    integer          m;
    integer          r;

    wire        wr_en   = psel_i & penable_i & pwrite_i;
    wire        rd_en   = psel_i & penable_i & ~pwrite_i;
    wire [3:0]  cmd_op  = pwdata_i[`TAS_CMD_OP_MSB:`TAS_CMD_OP_LSB];
    wire [1:0]  cmd_ch  = pwdata_i[`TAS_CMD_CH_MSB:`TAS_CMD_CH_LSB];
    wire        cmd_arg = pwdata_i[`TAS_CMD_ARG_BIT];
    wire        cmd_wr  = wr_en & (paddr_i == `TAS_OFF_CMD);
    // single-channel builds reject channel b suffix
    wire        ch_ok   = (cmd_ch == `TAS_SUFFIX_A) | ((cmd_ch == `TAS_SUFFIX_B) & (NUM_CH > 1));
    wire        ch_idx  = (cmd_ch == `TAS_SUFFIX_B);
    wire        per_ch  = (cmd_op == `TAS_OP_ABORT) | (cmd_op == `TAS_OP_SINGLE) |
                          (cmd_op == `TAS_OP_CONT) | (cmd_op == `TAS_OP_TRIG_NOW);
    // effective repeat arming, per channel or all-channel
    wire [1:0]  rep     = cont_reg | {2{cont_all_reg}};

    // register selects, one per mapped word
    wire        sel_cmd    = (paddr_i == `TAS_OFF_CMD);
    wire        sel_cfg    = (paddr_i == `TAS_OFF_CFG);
    wire        sel_status = (paddr_i == `TAS_OFF_STATUS);
    wire        sel_istat  = (paddr_i == `TAS_OFF_IRQ_STAT);
    wire        sel_ien    = (paddr_i == `TAS_OFF_IRQ_EN);
    wire        sel_iclr   = (paddr_i == `TAS_OFF_IRQ_CLR);
    wire        sel_err    = (paddr_i == `TAS_OFF_ERR);
    wire        sel_any    = sel_cmd | sel_cfg | sel_status | sel_istat | sel_ien | sel_iclr | sel_err;

    ////////////////////////////////////////////////////////////////////////
    // status word fields; spare bits read as zero so fresh flags sit at the top
    wire [7:0]  stat_res_a   = result_reg[0][7:0];
    wire [7:0]  stat_res_b   = result_reg[1][7:0];
    wire [1:0]  stat_state_a = state_reg[0];
    wire [1:0]  stat_state_b = state_reg[1];
    wire        stat_pend_a  = (state_reg[0] != ST_IDLE);
    wire        stat_pend_b  = (state_reg[1] != ST_IDLE);
    wire [1:0]  stat_rep     = rep;
    wire        stat_rep_all = cont_all_reg;
    wire [4:0]  stat_spare   = 5'h00;
    wire [1:0]  stat_fresh   = fresh_reg;
    wire [31:0] status_word  = {stat_fresh, stat_spare, stat_rep_all, stat_rep, stat_pend_b, stat_pend_a,
                                stat_state_b, stat_state_a, stat_res_b, stat_res_a};

    ////////////////////////////////////////////////////////////////////////
    // trigger qualification; bus and hold sources only fire by trigger-now
    always @* begin
        src[0]   = cfg_reg[`TAS_CFG_SRC_A_LSB+2:`TAS_CFG_SRC_A_LSB];
        src[1]   = cfg_reg[`TAS_CFG_SRC_B_LSB+2:`TAS_CFG_SRC_B_LSB];
        trig_hit = 2'b00;
        for (t = 0; t < 2; t = t + 1) begin
            case (src[t])
                `TAS_SRC_EXT: begin
                    trig_hit[t] = ext_trig_i[t];
                end
                `TAS_SRC_INT: begin
                    trig_hit[t] = int_trig_i[t];
                end
                `TAS_SRC_IMM: begin
                    trig_hit[t] = 1'b1;
                end
                default: begin
                    trig_hit[t] = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing next state
    always @* begin
        cont_next     = cont_reg;
        cont_all_next = cont_all_reg;
        err_next      = `TAS_ERR_NONE;
        err_set       = 1'b0;
        done_set      = 2'b00;
        for (c = 0; c < 2; c = c + 1) begin
            state_next[c] = state_reg[c];
        end
        // autonomous progress; commands keep being taken meanwhile
        for (c = 0; c < 2; c = c + 1) begin
            case (state_reg[c])
                ST_IDLE: begin
                    if (rep[c])
                        state_next[c] = ST_WAIT;
                end
                ST_WAIT: begin
                    if (trig_hit[c])
                        state_next[c] = ST_MEAS;
                end
                ST_MEAS: begin
                    if (cnt_reg[c] == 16'h0000) begin
                        done_set[c]   = 1'b1;
                        // repeat goes straight back to waiting
                        state_next[c] = rep[c] ? ST_WAIT : ST_IDLE;
                    end
                end
                default: state_next[c] = ST_IDLE;
            endcase
        end
        if (cmd_wr) begin
            if (per_ch & ~ch_ok) begin
                err_next = `TAS_ERR_SUFFIX;
                err_set  = 1'b1;
            end else begin
                case (cmd_op)
                    `TAS_OP_ABORT: begin
                        // only state changes, config stays put
                        if (state_reg[ch_idx] != ST_IDLE)
                            state_next[ch_idx] = rep[ch_idx] ? ST_WAIT : ST_IDLE;
                    end
                    `TAS_OP_SINGLE: begin
                        if ((state_reg[ch_idx] != ST_IDLE) | rep[ch_idx]) begin
                            err_next = `TAS_ERR_INIT_IGN;
                            err_set  = 1'b1;
                        end else begin
                            state_next[ch_idx] = (src[ch_idx] == `TAS_SRC_IMM) ? ST_MEAS : ST_WAIT;
                        end
                    end
                    `TAS_OP_SINGLE_ALL: begin
                        if ((state_reg[0] != ST_IDLE) | (state_reg[1] != ST_IDLE) | (|rep)) begin
                            err_next = `TAS_ERR_INIT_IGN;
                            err_set  = 1'b1;
                        end else begin
                            for (c = 0; c < NUM_CH; c = c + 1)
                                state_next[c] = (src[c] == `TAS_SRC_IMM) ? ST_MEAS : ST_WAIT;
                        end
                    end
                    `TAS_OP_CONT: cont_next[ch_idx] = cmd_arg;
                    `TAS_OP_CONT_ALL: begin
                        cont_all_next = cmd_arg;
                        cont_next     = {2{cmd_arg}};
                    end
                    `TAS_OP_TRIG_NOW: begin
                        if (state_reg[ch_idx] == ST_WAIT) begin
                            state_next[ch_idx] = ST_MEAS;
                        end else begin
                            err_next = `TAS_ERR_TRIG_IGN;
                            err_set  = 1'b1;
                        end
                    end
                    `TAS_OP_LOCAL: begin
                        for (c = 0; c < 2; c = c + 1)
                            if ((src[c] != `TAS_SRC_INT) & (src[c] != `TAS_SRC_EXT))
                                cont_next[c] = 1'b1;
                    end
                    default: begin
                        err_next = err_next;
                    end
                endcase
            end
        end
        if (NUM_CH < 2) begin
            state_next[1] = ST_IDLE;
            cont_next[1]  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state, repeat settings and result memory
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            for (k = 0; k < 2; k = k + 1) begin
                state_reg[k]  <= ST_IDLE;
                result_reg[k] <= {RES_W{1'b0}};
            end
            cont_reg     <= 2'b00;
            cont_all_reg <= 1'b0;
        end else begin
            cont_reg     <= cont_next;
            cont_all_reg <= cont_all_next;
            for (k = 0; k < 2; k = k + 1) begin
                state_reg[k] <= state_next[k];
                if (done_set[k])
                    result_reg[k] <= (k == 0) ? meas_data_a_i : meas_data_b_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // measurement timers, loaded on entry to measuring
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            for (m = 0; m < 2; m = m + 1)
                cnt_reg[m] <= 16'h0000;
        end else begin
            for (m = 0; m < 2; m = m + 1) begin
                if ((state_next[m] == ST_MEAS) & (state_reg[m] != ST_MEAS))
                    cnt_reg[m] <= MEAS_CYC[15:0] - 16'h0001;
                else if (cnt_reg[m] != 16'h0000)
                    cnt_reg[m] <= cnt_reg[m] - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host config, error code and fresh-result flags
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            cfg_reg   <= {1'b0, `TAS_SRC_IMM, 1'b0, `TAS_SRC_IMM};
            fresh_reg <= 2'b00;
            err_reg   <= `TAS_ERR_NONE;
        end else begin
            // result stays until fetched; a new result wins over the fetch
            for (r = 0; r < 2; r = r + 1) begin
                if (done_set[r])
                    fresh_reg[r] <= 1'b1;
                else if (rd_en & sel_status)
                    fresh_reg[r] <= 1'b0;
            end
            if (wr_en & sel_cfg)
                cfg_reg <= pwdata_i[7:0];
            // a new error wins over the clearing read
            if (err_set)
                err_reg <= err_next;
            else if (rd_en & sel_err)
                err_reg <= `TAS_ERR_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over clear
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_stat_reg <= {`TAS_IRQ_W{1'b0}};
            irq_en_reg   <= {`TAS_IRQ_W{1'b0}};
            irq_o        <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                             ~((wr_en & (paddr_i == `TAS_OFF_IRQ_CLR)) ? pwdata_i[`TAS_IRQ_W-1:0]
                                                                        : {`TAS_IRQ_W{1'b0}})) |
                            {err_set, done_set};
            if (wr_en & (paddr_i == `TAS_OFF_IRQ_EN))
                irq_en_reg <= pwdata_i[`TAS_IRQ_W-1:0];
            irq_o <= |(irq_stat_reg & irq_en_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux; unmapped words read zero and raise slverr
    reg  [31:0] rd_word;
    always @* begin
        rd_word = 32'h00000000;
        case (paddr_i)
            `TAS_OFF_CMD: begin
                rd_word = 32'h00000000;
            end
            `TAS_OFF_CFG: begin
                rd_word = {24'h000000, cfg_reg};
            end
            `TAS_OFF_STATUS: begin
                rd_word = status_word;
            end
            `TAS_OFF_IRQ_STAT: begin
                rd_word = {{(32-`TAS_IRQ_W){1'b0}}, irq_stat_reg};
            end
            `TAS_OFF_IRQ_EN: begin
                rd_word = {{(32-`TAS_IRQ_W){1'b0}}, irq_en_reg};
            end
            `TAS_OFF_IRQ_CLR: begin
                rd_word = 32'h00000000;
            end
            `TAS_OFF_ERR: begin
                rd_word = {24'h000000, err_reg};
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave, no wait states, registered outputs
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            // ready answers the setup cycle, so every access phase is one cycle long
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
            if (psel_i & ~penable_i) begin
                prdata_o  <= rd_word;
                pslverr_o <= ~sel_any;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status outputs follow next state so they line up with the state registers
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            pending_o   <= 2'b00;
            measuring_o <= 2'b00;
        end else begin
            for (j = 0; j < 2; j = j + 1) begin
                pending_o[j]   <= (state_next[j] != ST_IDLE);
                measuring_o[j] <= (state_next[j] == ST_MEAS);
            end
        end
    end
endmodule // tas_sequencer

// file: tb/tas_seq_chk.sv
// port assertions for the trigger arming sequencer
module tas_seq_chk #(
    parameter MEAS_CYC = 20
) (
    // clock and reset
    input wire        ref_clk_i,
    input wire        srst_i,
    // apb
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire        pready_o,
    input wire        pslverr_o,
    // status
    input wire [1:0]  pending_o,
    input wire [1:0]  measuring_o,
    input wire        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    logic [7:0] meas_cnt_reg;
    wire        wr_cmd = psel_i && penable_i && pwrite_i && pready_o && paddr_i == 12'h000;
    wire        wr_en0 = psel_i && penable_i && pwrite_i && pready_o && paddr_i == 12'h010 && pwdata_i[2:0] == 3'h0;
    ////////////////////////////////////////////////////////////////
    // counts how long channel a stays measuring
    always @(posedge ref_clk_i) begin
        if (srst_i || !measuring_o[0])
            meas_cnt_reg <= 8'h00;
        else
            meas_cnt_reg <= meas_cnt_reg + 8'h01;
    end
    pready_once_a: assert property (pready_o |=> !pready_o) else $error("ready held too long");
    pready_next_a: assert property (psel_i && !penable_i |=> pready_o) else $error("ready late");
    slverr_map_a: assert property (pready_o |-> pslverr_o == (paddr_i > 12'h018)) else $error("slverr wrong");
    meas_pend_a: assert property ((measuring_o & ~pending_o) == 2'h0) else $error("measuring while idle");
    trig_now_a: assert property (wr_cmd && pwdata_i[5:0] == 6'h16 && pending_o[0] && !measuring_o[0]
        |-> ##[1:2] measuring_o[0]) else $error("trigger now ignored");
    meas_len_a: assert property ($fell(measuring_o[0]) |-> meas_cnt_reg == MEAS_CYC)
        else $error("measurement length wrong");
    arm_pend_a: assert property (wr_cmd && pwdata_i[5:0] == 6'h12 && !pending_o[0]
        |-> ##[1:2] pending_o[0]) else $error("arm did not set pending");
    irq_mask_a: assert property (wr_en0 |-> ##2 !irq_o) else $error("masked irq still high");
    pend_cause_a: assert property ($rose(pending_o[0]) |-> $past(wr_cmd) || $past(wr_cmd, 2)
        || $past(wr_cmd, 3)) else $error("channel left idle on its own");
endmodule // tas_seq_chk
bind tas_sequencer tas_seq_chk #(.MEAS_CYC(MEAS_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pending_o(pending_o), .measuring_o(measuring_o), .irq_o(irq_o));

// file: tb/tas_host_model.sv
// apb master model standing in for the remote host
module tas_host_model (
    // clock
    input  wire         ref_clk_i,
    // apb master side
    output logic        psel_o,
    output logic        penable_o,
    output logic        pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input  wire         pready_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
    end
    // results are only fetched by a status read from here
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge ref_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= data;
        @(posedge ref_clk_i);
        penable_o <= 1'b1;
        @(posedge ref_clk_i);
        // request held until ready, no matter how slow
        while (pready_i !== 1'b1) @(posedge ref_clk_i);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule // tas_host_model

// file: tb/testbench.sv
// self-checking bench for the trigger arming sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  ext_trig = 2'h0;
    logic [1:0]  pending, measuring;
    logic [15:0] meas_a = 16'h0, meas_b = 16'h0;
    logic [64:0] exp_q[$];
    logic [64:0] note;
    int          err_count = 0, num_checks = 0, i;
    int          seed = 32'he7a39de8;
    tas_host_model host (.ref_clk_i(ref_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready));
    tas_sequencer #(.NUM_CH(2), .RES_W(16), .MEAS_CYC(4)) uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ext_trig_i(ext_trig), .int_trig_i(2'h0),
        .meas_data_a_i(meas_a), .meas_data_b_i(meas_b), .pending_o(pending), .measuring_o(measuring),
        .irq_o(irq));
    always #25 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // each transfer leaves a note {slverr, mask, data}; writes get a zero mask, so their read data is not checked
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        exp_q.push_back({1'b0, 32'h0, 32'h0});
        host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({a > 12'h018, m, e});
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        if (psel && penable && pready === 1'b1) begin
            note = exp_q.pop_front();
            cmp({31'h0, pslverr}, {31'h0, note[64]});
            cmp(prdata & note[63:32], note[31:0]);
        end
    end
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        err_count++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rd(12'h008, 32'h01FF_0000, 32'h0);
        rd(12'h004, 32'h77, 32'h33);
        rd(12'h100, 32'h0, 32'h0);
        wr(12'h004, 32'h12);
        wr(12'h000, 32'h12);
        wr(12'h000, 32'h22);
        rd(12'h008, 32'h003F_0000, 32'h0035_0000);
        wr(12'h000, 32'h12);
        rd(12'h018, 32'hFF, 32'hD5);
        wr(12'h000, 32'h11);
        rd(12'h008, 32'h0013_0000, 32'h0);
        wr(12'h000, 32'h12);
        {meas_a, meas_b} <= $random(seed);
        wr(12'h000, 32'h16);
        ext_trig <= 2'h2;
        @(posedge ref_clk_i);
        ext_trig <= 2'h0;
        for (i = 0; i < 40 && pending !== 2'h0; i++) @(posedge ref_clk_i);
        cmp({30'h0, pending}, 32'h0);
        rd(12'h008, 32'hC00F_FFFF, {2'h3, 14'h0, meas_b[7:0], meas_a[7:0]});
        wr(12'h000, 32'h26);
        rd(12'h018, 32'hFF, 32'hD3);
        wr(12'h000, 32'h113);
        wr(12'h000, 32'h11);
        rd(12'h008, 32'h0053_0000, 32'h0051_0000);
        wr(12'h000, 32'h12);
        rd(12'h018, 32'hFF, 32'hD5);
        wr(12'h000, 32'h104);
        rd(12'h008, 32'h01C0_0000, 32'h01C0_0000);
        wr(12'h000, 32'h004);
        rd(12'h008, 32'h01C0_0000, 32'h0);
        wr(12'h004, 32'h21);
        wr(12'h000, 32'h007);
        rd(12'h008, 32'h00C0_0000, 32'h0080_0000);
        srst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rd(12'h008, 32'h01FF_0000, 32'h0);
        wr(12'h000, 32'h12);
        repeat (2) @(posedge ref_clk_i);
        cmp({31'h0, measuring[0]}, 32'h1);
        wr(12'h000, 32'h16);
        rd(12'h00C, 32'h4, 32'h4);
        cmp({31'h0, irq}, 32'h0);
        wr(12'h010, 32'h4);
        repeat (2) @(posedge ref_clk_i);
        cmp({31'h0, irq}, 32'h1);
        wr(12'h010, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        cmp({31'h0, irq}, 32'h0);
        wr(12'h014, 32'h4);
        rd(12'h00C, 32'h4, 32'h0);
        final_report();
    end
endmodule // testbench
